// >>> rtl/vcr_pkg.sv
// Constants and carrier types for the channel 0 resource register bank
`default_nettype none

package vcr_pkg;

  // Register window
  localparam int unsigned VCR_ADDR_W     = 12;
  localparam int unsigned VCR_DATA_W     = 32;
  localparam int unsigned VCR_NUM_TC     = 8;
  localparam int unsigned VCR_TC_W       = 3;
  localparam logic [11:0] VCR_CAP_OFFSET = 12'h110;
  localparam logic [11:0] VCR_CTL_OFFSET = 12'h114;

  // Field positions of the capability and control words
  localparam int VCR_RSNP_BIT = 15;
  localparam int VCR_EN_BIT   = 31;
  localparam int VCR_ID_MSB   = 26;
  localparam int VCR_ID_LSB   = 24;
  localparam int VCR_RSV1_MSB = 30;
  localparam int VCR_RSV1_LSB = 27;
  localparam int VCR_RSV2_MSB = 23;
  localparam int VCR_RSV2_LSB = 8;
  localparam int VCR_MAP_MSB  = 7;
  localparam int VCR_MAP_LSB  = 1;
  localparam int VCR_TC0_BIT  = 0;
  localparam int VCR_MAP_BYTE = 0;

  // Fixed and reset values
  localparam logic [31:0] VCR_CAP_RESET  = 32'h0000_0000;
  localparam logic [31:0] VCR_CTL_RESET  = 32'h8000_00ff;
  localparam logic        VCR_RSNP_VALUE = 1'h0;
  localparam logic        VCR_EN_VALUE   = 1'h1;
  localparam logic [2:0]  VCR_CHAN_ID    = 3'h0;
  localparam logic        VCR_TC0_VALUE  = 1'h1;
  localparam logic [6:0]  VCR_MAP_RESET  = 7'h7f;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } vcr_req_t;

  // Transaction offered for admission onto channel 0
  typedef struct packed {
    logic       valid;
    logic       no_snoop;
    logic [2:0] tc;
  } vcr_txn_t;

endpackage

`default_nettype wire

// >>> rtl/vcr_regs.sv
// Channel 0 resource capability and control registers with traffic admission
//
// Notes on behaviour
// - Capability reject-snoop bit 15 reads zero.
// - Set bit would refuse snooped traffic as unsupported.
// - Control bit 31 enable reads one, read-only.
// - Channel identifier bits 26:24 fixed at zero.
// - Map bits 7:1 writable, reset 7Fh.
// - All set map classes route to channel 0.
// - Bit 0 reads one; class 0 always mapped.
`default_nettype none

module vcr_regs
  import vcr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register access port, one request per valid cycle
  input  wire logic                  req_valid,
  input  wire vcr_req_t              req,
  output logic                       rsp_valid,
  output logic [VCR_DATA_W-1:0]      rsp_rdata,
  // Transaction admission
  input  wire vcr_txn_t              txn,
  output logic                       txn_accept,
  output logic                       txn_unsupported,
  // Live view of the channel 0 configuration
  output logic [VCR_NUM_TC-1:0]      tc_vc0_map,
  output logic                       channel0_enable_flag,
  output logic                       reject_snoop_required
);

  logic [VCR_MAP_MSB-VCR_MAP_LSB:0] map_ff;
  logic [VCR_MAP_MSB-VCR_MAP_LSB:0] nxt_map;
  logic                             rsp_valid_ff;
  logic [VCR_DATA_W-1:0]            rdata_ff;
  logic [VCR_DATA_W-1:0]            nxt_rdata;
  logic                             accept_ff;
  logic                             unsup_ff;
  logic [VCR_DATA_W-1:0]            cap_word;
  logic [VCR_DATA_W-1:0]            ctl_word;

  // Address decode on word granularity; the low two address bits are ignored
  wire hit_cap  = req.addr[VCR_ADDR_W-1:2] == VCR_CAP_OFFSET[VCR_ADDR_W-1:2];
  wire hit_ctl  = req.addr[VCR_ADDR_W-1:2] == VCR_CTL_OFFSET[VCR_ADDR_W-1:2];
  wire rd_req   = req_valid && !req.wr;
  // Only the map byte lane can change state; everything else is dropped
  wire wr_map   = req_valid && req.wr && hit_ctl && req.be[VCR_MAP_BYTE];

  // Capability word: all zero, snoop rejection never requested
  always_comb begin
    cap_word               = '0;
    cap_word[VCR_RSNP_BIT] = VCR_RSNP_VALUE;
  end

  // Control word assembled from constants and the live map
  always_comb begin
    ctl_word                         = '0;
    ctl_word[VCR_EN_BIT]             = VCR_EN_VALUE;
    ctl_word[VCR_ID_MSB:VCR_ID_LSB]  = VCR_CHAN_ID;
    ctl_word[VCR_MAP_MSB:VCR_MAP_LSB] = map_ff;
    ctl_word[VCR_TC0_BIT]            = VCR_TC0_VALUE;
  end

  // Read mux; unmapped addresses and writes answer zero
  assign nxt_rdata = !rd_req ? '0 :
                     hit_cap ? cap_word :
                     hit_ctl ? ctl_word : '0;
  assign nxt_map   = wr_map ? req.wdata[VCR_MAP_MSB:VCR_MAP_LSB] : map_ff;

  // Full per-class map: class 0 hard-wired, the rest from the register
  assign tc_vc0_map            = {map_ff, VCR_TC0_VALUE};
  assign channel0_enable_flag  = VCR_EN_VALUE;
  assign reject_snoop_required = VCR_RSNP_VALUE;

  // Admission: refuse unmapped classes, and snooped traffic if rejection is on.
  // Clearing a map bit takes effect next cycle; draining in-flight traffic of
  // that class first is left to software.
  wire tc_hit     = tc_vc0_map[txn.tc];
  wire snoop_bad  = reject_snoop_required && !txn.no_snoop;
  wire nxt_unsup  = txn.valid && (snoop_bad || !tc_hit);
  wire nxt_accept = txn.valid && !snoop_bad && tc_hit;

  // Map register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      map_ff <= VCR_MAP_RESET;
    end else begin
      map_ff <= nxt_map;
    end
  end

  // Register port answer, one cycle after each request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_ff <= 1'h0;
      rdata_ff     <= '0;
    end else begin
      rsp_valid_ff <= req_valid;
      rdata_ff     <= nxt_rdata;
    end
  end

  // Admission verdict, registered so the outputs are glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accept_ff <= 1'h0;
      unsup_ff  <= 1'h0;
    end else begin
      accept_ff <= nxt_accept;
      unsup_ff  <= nxt_unsup;
    end
  end

  assign rsp_valid       = rsp_valid_ff;
  assign rsp_rdata       = rdata_ff;
  assign txn_accept      = accept_ff;
  assign txn_unsupported = unsup_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_read_cap;
    req_valid && !req.wr && hit_cap;
  endsequence

  sequence s_read_ctl;
    req_valid && !req.wr && hit_ctl;
  endsequence

  sequence s_map_write;
    req_valid && req.wr && hit_ctl && req.be[VCR_MAP_BYTE];
  endsequence

  sequence s_snooped_mapped;
    txn.valid && !txn.no_snoop && tc_vc0_map[txn.tc];
  endsequence

  cap_read_zero_a: assert property (s_read_cap |=> rsp_valid && rsp_rdata == VCR_CAP_RESET)
    else $error("capability word not zero");

  snoop_allowed_a: assert property (s_snooped_mapped |=> txn_accept && !txn_unsupported)
    else $error("snooped transaction refused");

  enable_bit_a: assert property (s_read_ctl |=> rsp_valid && rsp_rdata[VCR_EN_BIT])
    else $error("channel enable bit read zero");

  chan_id_zero_a: assert property (s_read_ctl |=> rsp_rdata[VCR_ID_MSB:VCR_ID_LSB] == VCR_CHAN_ID)
    else $error("channel identifier not zero");

  map_readback_a: assert property (s_map_write ##1 s_read_ctl
      |=> rsp_rdata[VCR_MAP_MSB:VCR_MAP_LSB] == $past(req.wdata[VCR_MAP_MSB:VCR_MAP_LSB], 2))
    else $error("map write not read back");

  multi_route_a: assert property (txn.valid && tc_vc0_map[txn.tc] && txn.no_snoop
      |=> txn_accept ##0 !txn_unsupported)
    else $error("mapped class not routed");

  unmapped_tc_a: assert property (txn.valid && !tc_vc0_map[txn.tc] |=> txn_unsupported && !txn_accept)
    else $error("unmapped class accepted");

  tc0_fixed_a: assert property (txn.valid && txn.tc == '0 && txn.no_snoop |=> txn_accept)
    else $error("class 0 not routed");

  ctl_reserved_a: assert property (s_read_ctl |=> rsp_rdata[VCR_RSV1_MSB:VCR_RSV1_LSB] == '0
      && rsp_rdata[VCR_RSV2_MSB:VCR_RSV2_LSB] == '0 && rsp_rdata[VCR_TC0_BIT])
    else $error("reserved control bits nonzero");

  ro_write_ignored_a: assert property (req_valid && req.wr && !(hit_ctl && req.be[VCR_MAP_BYTE])
      |=> $stable(map_ff) && rsp_rdata == '0)
    else $error("ignored write changed state");

  // Answer port: one strobe per taken request, quiet otherwise, so stale read
  // data can never pass for a fresh answer
  sequence s_idle_port;
    !req_valid;
  endsequence

  rsp_timing_a: assert property (req_valid |=> rsp_valid)
    else $error("request not answered");

  rsp_quiet_a: assert property (s_idle_port |=> !rsp_valid && rsp_rdata == '0)
    else $error("answer without request");

  // The taken map write is what the register holds one edge later
  map_write_a: assert property (s_map_write |=> map_ff == $past(req.wdata[VCR_MAP_MSB:VCR_MAP_LSB]))
    else $error("map write lost");

  // Leaving reset: map back at its default and both answer ports silent;
  // a mid-run reset must behave exactly like the first one
  sequence s_reset_left;
    $fell(rst);
  endsequence

  reset_state_a: assert property (s_reset_left |-> map_ff == VCR_MAP_RESET && !rsp_valid)
    else $error("map not reloaded by reset");

  reset_quiet_a: assert property (s_reset_left |-> !txn_accept && !txn_unsupported)
    else $error("verdict straight out of reset");

  // One verdict per offered transaction and none without one
  verdict_once_a: assert property (txn.valid |=> txn_accept ^ txn_unsupported)
    else $error("verdict not exactly one");

  no_verdict_a: assert property (!txn.valid |=> !txn_accept && !txn_unsupported)
    else $error("verdict without transaction");

  // Per-class routing, checked class by class so a broken index into the
  // map cannot hide behind the classes that happen to be exercised
  for (genvar gi = 0; gi < VCR_NUM_TC; gi++) begin : g_class
    class_route_a: assert property (txn.valid && !snoop_bad && txn.tc == VCR_TC_W'(gi) && tc_vc0_map[gi]
        |=> txn_accept)
      else $error("mapped class refused");
    class_refuse_a: assert property (txn.valid && txn.tc == VCR_TC_W'(gi) && !tc_vc0_map[gi]
        |=> txn_unsupported)
      else $error("unmapped class admitted");
  end

endmodule

`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the channel 0 resource register bank
`default_nettype none

module testbench;
  import vcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk;
  logic                  rst;
  logic                  req_valid;
  vcr_req_t              req;
  logic                  rsp_valid;
  logic [VCR_DATA_W-1:0] rsp_rdata;
  vcr_txn_t              txn;
  logic                  txn_accept;
  logic                  txn_unsupported;
  logic [VCR_NUM_TC-1:0] tc_vc0_map;
  logic                  channel0_enable_flag;
  logic                  reject_snoop_required;
  int                    error_cnt;
  int                    check_count;

  vcr_regs vcr_regs_i (
    .clk                   (clk),
    .rst                   (rst),
    .req_valid             (req_valid),
    .req                   (req),
    .rsp_valid             (rsp_valid),
    .rsp_rdata             (rsp_rdata),
    .txn                   (txn),
    .txn_accept            (txn_accept),
    .txn_unsupported       (txn_unsupported),
    .tc_vc0_map            (tc_vc0_map),
    .channel0_enable_flag  (channel0_enable_flag),
    .reject_snoop_required (reject_snoop_required)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One register access; the answer strobe is looked at in its single cycle
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        input logic [3:0] be, input logic [31:0] exp);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{wr: wr, addr: addr, wdata: wdata, be: be};
    @(negedge clk);
    req_valid = 1'b0;
    check("rsp_valid", {31'h0, rsp_valid}, 32'h1);
    check("rsp_rdata", rsp_rdata, exp);
  endtask

  // One offered transaction; exactly one of the two verdict pulses must show
  task automatic offer(input logic [2:0] tc, input logic ns, input logic acc);
    @(negedge clk);
    txn = '{valid: 1'b1, no_snoop: ns, tc: tc};
    @(negedge clk);
    txn = '0;
    check("txn_accept", {31'h0, txn_accept}, {31'h0, acc});
    check("txn_unsupported", {31'h0, txn_unsupported}, {31'h0, !acc});
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 200 cycles
  initial begin
    #(8 * 2000);
    error_cnt++;
    complete_run();
  end

  initial begin
    error_cnt = 0;
    check_count = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    txn = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    check("tc_vc0_map", {24'h0, tc_vc0_map}, 32'hff);
    check("enable_flag", {31'h0, channel0_enable_flag}, 32'h1);
    check("reject_snoop", {31'h0, reject_snoop_required}, 32'h0);
    access(1'b0, 12'h110, 32'h0, 4'h0, 32'h0000_0000);
    access(1'b0, 12'h114, 32'h0, 4'h0, 32'h8000_00ff);
    $display("Test reset values done");
    // Ones into reserved and identifier bits 30:8 must not stick; bits 31 and 0 are written as zero
    access(1'b1, 12'h114, 32'h7fff_ff06, 4'hf, 32'h0);
    access(1'b0, 12'h114, 32'h0, 4'h0, 32'h8000_0007);
    check("tc_vc0_map", {24'h0, tc_vc0_map}, 32'h07);
    for (int i = 0; i < 8; i++) begin
      offer(i[2:0], i[0], i < 3);
    end
    $display("Test map routing done");
    access(1'b1, 12'h110, 32'hffff_ffff, 4'hf, 32'h0);
    access(1'b0, 12'h110, 32'h0, 4'h0, 32'h0000_0000);
    access(1'b1, 12'h114, 32'hffff_ffff, 4'he, 32'h0);
    access(1'b0, 12'h114, 32'h0, 4'h0, 32'h8000_0007);
    access(1'b1, 12'h200, 32'hffff_ffff, 4'hf, 32'h0);
    access(1'b0, 12'h200, 32'h0, 4'h0, 32'h0000_0000);
    $display("Test ignored writes done");
    // Clearing the whole writable map still leaves class 0 routed
    access(1'b1, 12'h114, 32'h0, 4'h1, 32'h0);
    access(1'b0, 12'h114, 32'h0, 4'h0, 32'h8000_0001);
    offer(3'h0, 1'b0, 1'b1);
    offer(3'h5, 1'b1, 1'b0);
    access(1'b1, 12'h114, 32'h0000_00fe, 4'h1, 32'h0);
    check("tc_vc0_map", {24'h0, tc_vc0_map}, 32'hff);
    offer(3'h7, 1'b0, 1'b1);
    $display("Test map clear and restore done");
    // Write then read on consecutive edges: the read already sees the new map
    @(negedge clk);
    req_valid = 1'b1;
    req = '{wr: 1'b1, addr: 12'h114, wdata: 32'h0000_00aa, be: 4'h1};
    @(negedge clk);
    check("rsp_valid", {31'h0, rsp_valid}, 32'h1);
    check("rsp_rdata", rsp_rdata, 32'h0);
    req = '{wr: 1'b0, addr: 12'h114, wdata: 32'h0, be: 4'h0};
    @(negedge clk);
    req_valid = 1'b0;
    check("rsp_rdata", rsp_rdata, 32'h8000_00ab);
    check("tc_vc0_map", {24'h0, tc_vc0_map}, 32'hab);
    $display("Test back-to-back access done");
    // A reset in mid-run reloads the map default
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check("tc_vc0_map", {24'h0, tc_vc0_map}, 32'hff);
    access(1'b0, 12'h114, 32'h0, 4'h0, 32'h8000_00ff);
    $display("Test mid-run reset done");
    complete_run();
  end

endmodule

`default_nettype wire
